// ==== core/rxfl_pkg.sv ====
// Package: register map, field positions and timing constants for the receive latch bank
package rxfl_pkg;
    localparam logic [7:0] RXFL_TAP_CTRL_OFF = 8'h8A;
    localparam logic [7:0] RXFL_TAP_SUPP_OFF = 8'h8B;
    localparam logic [7:0] RXFL_HDLC_SUPP_OFF = 8'h8D;
    localparam logic [7:0] RXFL_ALARM_OFF = 8'h90;
    localparam logic [7:0] RXFL_FRAMING_OFF = 8'h91;
    localparam logic [7:0] RXFL_LOOP_OFF = 8'h92;
    localparam logic [7:0] RXFL_MODE_OFF = 8'h9F;
    localparam logic [7:0] RXFL_RESET_VAL = 8'h00;
    localparam int RXFL_TAP_SRC_BIT = 2;
    localparam int RXFL_TAP_UNFR_BIT = 1;
    localparam int RXFL_TAP_EN_BIT = 0;
    localparam int RXFL_MODE_E1_BIT = 0;
    localparam int RXFL_MODE_CRC4_BIT = 1;
    localparam int RXFL_MODE_SA_BIT = 2;
    localparam int RXFL_MODE_ES_BIT = 3;
    localparam logic [7:0] RXFL_LOS_ZEROS = 8'hC0;
    localparam logic [4:0] RXFL_ZRUN_SHORT = 5'h08;
    localparam logic [4:0] RXFL_ZRUN_LONG = 5'h10;
    localparam logic [2:0] RXFL_SEF_WINDOW = 3'h6;
    localparam logic [1:0] RXFL_SEF_LIMIT = 2'h2;
    localparam logic [9:0] RXFL_CRC_WINDOW = 10'h3E8;
    localparam logic [9:0] RXFL_CRC_LIMIT = 10'h393;
    localparam logic [1:0] RXFL_CAS_LIMIT = 2'h2;
    localparam logic [1:0] RXFL_FAS_LIMIT = 2'h3;
    localparam logic [4:0] RXFL_TS16_FRAMES = 5'h10;
    localparam int RXFL_CLK_MHZ = 200;
    localparam int RXFL_CMF_PERIOD_US = 2000;
    localparam int RXFL_CMF_CYCLES = RXFL_CMF_PERIOD_US * RXFL_CLK_MHZ;
    localparam int RXFL_AF_PERIOD_US = 250;
    localparam int RXFL_AF_CYCLES = RXFL_AF_PERIOD_US * RXFL_CLK_MHZ;

    typedef struct packed {
        logic remoteAlarm;
        logic allOnesAlarm;
        logic signalLoss;
        logic frameLoss;
    } rxfl_cond_t;

    typedef struct packed {
        logic frameStart;
        logic framingBitSlot;
        logic framingBitError;
        logic resyncDone;
        logic alignChanged;
        logic b8zsCodeword;
        logic crcWordDone;
        logic crcWordError;
        logic mfWordDone;
        logic mfWordError;
        logic fasWordDone;
        logic fasWordError;
        logic ts16Valid;
        logic [7:0] ts16Byte;
        logic mfBoundary;
        logic crcMfBoundary;
    } rxfl_frame_t;
endpackage : rxfl_pkg

// ==== core/rxfl_latch_bank.sv ====
// Receive framer latched status bank with test and HDLC tap suppress masks
//
// Summary of operation
// - Tap source bit 0 takes framer data; 1 takes transmit data.
// - In T1, unframed select 1 lets tap clock the framing bit.
// - Tap is active only while its enable bit is one.
// - Test tap suppress mask bits exclude matching channel bits; reset zero.
// - HDLC mask excludes channel bits; Sa mode bits 4..0 suppress Sa4..Sa8.
// - All alarm status flags latch and may request interrupts.
// - Upper alarm flags latch falling edges, lower flags rising edges.
// - All-ones alarm asserts on unframed all-ones line pattern.
// - Loss of signal asserts after 192 consecutive zeros.
// - T1 framing event register latches but never requests interrupts.
// - Alignment change event latches when resync changes alignment.
// - T1 latches runs of at least eight and sixteen zeros.
// - T1 latches B8ZS codeword event regardless of decoding mode.
// - T1 latches framing bit error for each errored framing bit.
// - E1 event register latches all; only bits 0..3 request interrupts.
// - E1 CRC resync event when 915 of 1000 codewords err.
// - E1 signaling resync event after two errored multiframe words.
// - E1 frame resync event after three errored alignment words.
// - E1 timeslot 16 all-ones and all-zeros events.
// - E1 CRC multiframe event each boundary, or every 2 ms without CRC-4.
// - E1 align frame event about every 250 us.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module rxfl_latch_bank
    import rxfl_pkg::*;
#(
    parameter int CMF_CYCLES = RXFL_CMF_CYCLES,
    parameter int AF_CYCLES = RXFL_AF_CYCLES
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [7:0] regRdData,
    input wire logic lineBitValid,
    input wire logic lineBit,
    input wire logic remoteAlarmCondition,
    input wire logic frameLossCondition,
    input wire rxfl_frame_t frameInfo,
    input wire logic framerBitValid,
    input wire logic framerBit,
    input wire logic txBitValid,
    input wire logic txBit,
    input wire logic [2:0] channelBitIndex,
    input wire logic hdlcBitValid,
    input wire logic hdlcBit,
    input wire logic [2:0] hdlcBitIndex,
    input wire logic hdlcSaSlot,
    output logic tapBitValid,
    output logic tapBit,
    output logic hdlcTapValid,
    output logic hdlcTapBit,
    output logic alarmIrq,
    output rxfl_cond_t alarmConditions
);
    logic [2:0] tapCtrl_reg;
    logic [7:0] tapSupp_reg;
    logic [7:0] hdlcSupp_reg;
    logic [3:0] mode_reg;
    logic [7:0] alarm_reg;
    logic [7:0] framing_reg;
    logic [7:0] framing_next;
    rxfl_cond_t cond_reg;
    rxfl_cond_t condPrev_reg;
    logic [7:0] zeroRun_reg;
    logic [7:0] onesRun_reg;
    logic [4:0] zrun_reg;
    logic [2:0] sefCnt_reg;
    logic [1:0] sefErr_reg;
    logic [9:0] crcCnt_reg;
    logic [9:0] crcErr_reg;
    logic [1:0] casErr_reg;
    logic [1:0] fasErr_reg;
    logic [4:0] ts16Frames_reg;
    logic [5:0] ts16Zeros_reg;
    logic ts16MfZero_reg;
    logic [31:0] cmfTimer_reg;
    logic [31:0] afTimer_reg;
    logic isE1;
    logic wrHit;
    logic [3:0] zerosInByte;

    assign isE1 = mode_reg[RXFL_MODE_E1_BIT];

    function automatic logic wr1c(input logic [7:0] a);
        wr1c = regWrStb && (regAddr == a);
    endfunction : wr1c

    function automatic logic [3:0] countZeros(input logic [7:0] b);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'h0, ~b[i]};
        end
        countZeros = n;
    endfunction : countZeros

    assign zerosInByte = countZeros(frameInfo.ts16Byte);
    assign wrHit = regWrStb;

    // Control registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tapCtrl_reg <= 3'h0;
            tapSupp_reg <= RXFL_RESET_VAL;
            hdlcSupp_reg <= RXFL_RESET_VAL;
            mode_reg <= 4'h0;
        end else if (wrHit) begin
            case (regAddr)
                RXFL_TAP_CTRL_OFF: tapCtrl_reg <= regWrData[2:0];
                RXFL_TAP_SUPP_OFF: tapSupp_reg <= regWrData;
                RXFL_HDLC_SUPP_OFF: hdlcSupp_reg <= regWrData;
                RXFL_MODE_OFF: mode_reg <= regWrData[3:0];
                default: ;
            endcase
        end
    end

    // Read port: data stands the cycle after the strobe only
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            regRdData <= 8'h00;
        end else if (regRdStb) begin
            case (regAddr)
                RXFL_TAP_CTRL_OFF: regRdData <= {5'h00, tapCtrl_reg};
                RXFL_TAP_SUPP_OFF: regRdData <= tapSupp_reg;
                RXFL_HDLC_SUPP_OFF: regRdData <= hdlcSupp_reg;
                RXFL_ALARM_OFF: regRdData <= alarm_reg;
                RXFL_FRAMING_OFF: regRdData <= framing_reg;
                RXFL_MODE_OFF: regRdData <= {4'h0, mode_reg};
                default: regRdData <= 8'h00;
            endcase
        end else begin
            regRdData <= 8'h00;
        end
    end

    // Line condition detectors
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            zeroRun_reg <= 8'h00;
            onesRun_reg <= 8'h00;
        end else if (lineBitValid) begin
            zeroRun_reg <= lineBit ? 8'h00 : (zeroRun_reg == RXFL_LOS_ZEROS ? zeroRun_reg
                                                 : zeroRun_reg + 8'h01);
            onesRun_reg <= !lineBit ? 8'h00 : (onesRun_reg == RXFL_LOS_ZEROS ? onesRun_reg
                                                 : onesRun_reg + 8'h01);
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cond_reg <= '0;
            condPrev_reg <= '0;
        end else begin
            cond_reg.remoteAlarm <= remoteAlarmCondition;
            // All ones with no framing found means unframed all-ones
            cond_reg.allOnesAlarm <= frameLossCondition &&
                                     (onesRun_reg == RXFL_LOS_ZEROS);
            cond_reg.signalLoss <= (zeroRun_reg == RXFL_LOS_ZEROS);
            cond_reg.frameLoss <= frameLossCondition;
            condPrev_reg <= cond_reg;
        end
    end
    assign alarmConditions = cond_reg;

    // Alarm latches: edge set wins over host write-one clear
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            alarm_reg <= RXFL_RESET_VAL;
        end else begin
            alarm_reg <= (alarm_reg & ~(wr1c(RXFL_ALARM_OFF) ? regWrData : 8'h00))
                       | {condPrev_reg & ~cond_reg, cond_reg & ~condPrev_reg};
        end
    end

    // T1/E1 event detectors
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            zrun_reg <= 5'h00;
        end else if (lineBitValid) begin
            zrun_reg <= lineBit ? 5'h00 : (zrun_reg == RXFL_ZRUN_LONG ? zrun_reg
                                              : zrun_reg + 5'h01);
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sefCnt_reg <= 3'h0;
            sefErr_reg <= 2'h0;
            crcCnt_reg <= 10'h000;
            crcErr_reg <= 10'h000;
            casErr_reg <= 2'h0;
            fasErr_reg <= 2'h0;
            ts16Frames_reg <= 5'h00;
            ts16Zeros_reg <= 6'h00;
            ts16MfZero_reg <= 1'b1;
        end else begin
            if (frameInfo.framingBitSlot) begin
                sefCnt_reg <= (sefCnt_reg == RXFL_SEF_WINDOW - 3'h1) ? 3'h0 : sefCnt_reg + 3'h1;
                sefErr_reg <= (sefCnt_reg == RXFL_SEF_WINDOW - 3'h1) ? 2'h0
                            : sefErr_reg + {1'b0, frameInfo.framingBitError &&
                                            sefErr_reg != RXFL_SEF_LIMIT};
            end
            if (frameInfo.crcWordDone) begin
                crcCnt_reg <= (crcCnt_reg == RXFL_CRC_WINDOW - 10'h001) ? 10'h000
                            : crcCnt_reg + 10'h001;
                crcErr_reg <= (crcCnt_reg == RXFL_CRC_WINDOW - 10'h001) ? 10'h000
                            : crcErr_reg + {9'h000, frameInfo.crcWordError};
            end
            if (frameInfo.mfWordDone) begin
                casErr_reg <= !frameInfo.mfWordError ? 2'h0
                            : (casErr_reg == RXFL_CAS_LIMIT ? casErr_reg : casErr_reg + 2'h1);
            end
            if (frameInfo.fasWordDone) begin
                fasErr_reg <= !frameInfo.fasWordError ? 2'h0
                            : (fasErr_reg == RXFL_FAS_LIMIT ? fasErr_reg : fasErr_reg + 2'h1);
            end
            if (frameInfo.ts16Valid) begin
                ts16Frames_reg <= (ts16Frames_reg == RXFL_TS16_FRAMES - 5'h01) ? 5'h00
                                : ts16Frames_reg + 5'h01;
                ts16Zeros_reg <= (ts16Frames_reg == RXFL_TS16_FRAMES - 5'h01) ? 6'h00
                               : ts16Zeros_reg + {2'h0, zerosInByte};
                ts16MfZero_reg <= frameInfo.mfBoundary ? 1'b1
                                : ts16MfZero_reg && (frameInfo.ts16Byte == 8'h00);
            end
        end
    end

    // Free-running timers stand in for the align frame event and for multiframe boundaries absent without CRC-4
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cmfTimer_reg <= 32'h0;
            afTimer_reg <= 32'h0;
        end else begin
            cmfTimer_reg <= (cmfTimer_reg == 32'(CMF_CYCLES - 1)) ? 32'h0 : cmfTimer_reg + 32'h1;
            afTimer_reg <= (afTimer_reg == 32'(AF_CYCLES - 1)) ? 32'h0 : afTimer_reg + 32'h1;
        end
    end

    always_comb begin
        framing_next = 8'h00;
        if (!isE1) begin
            framing_next[5] = frameInfo.resyncDone && frameInfo.alignChanged;
            framing_next[4] = lineBitValid && !lineBit &&
                              zrun_reg == RXFL_ZRUN_SHORT - 5'h01;
            framing_next[3] = lineBitValid && !lineBit &&
                              zrun_reg == RXFL_ZRUN_LONG - 5'h01;
            framing_next[2] = frameInfo.framingBitSlot && frameInfo.framingBitError &&
                              sefErr_reg == RXFL_SEF_LIMIT - 2'h1;
            // The codeword needs bipolar violations, so the line decoder flags it
            framing_next[1] = frameInfo.b8zsCodeword;
            framing_next[0] = frameInfo.framingBitSlot && frameInfo.framingBitError;
        end else begin
            framing_next[6] = frameInfo.crcWordDone && frameInfo.crcWordError &&
                              crcErr_reg == RXFL_CRC_LIMIT - 10'h001;
            framing_next[5] = frameInfo.mfWordDone && frameInfo.mfWordError &&
                              casErr_reg == RXFL_CAS_LIMIT - 2'h1;
            framing_next[4] = frameInfo.fasWordDone && frameInfo.fasWordError &&
                              fasErr_reg == RXFL_FAS_LIMIT - 2'h1;
            framing_next[3] = frameInfo.ts16Valid &&
                              ts16Frames_reg == RXFL_TS16_FRAMES - 5'h01 &&
                              (ts16Zeros_reg + {2'h0, zerosInByte}) < 6'h03;
            framing_next[2] = frameInfo.ts16Valid && frameInfo.mfBoundary &&
                              ts16MfZero_reg && frameInfo.ts16Byte == 8'h00;
            framing_next[1] = mode_reg[RXFL_MODE_CRC4_BIT] ? frameInfo.crcMfBoundary
                            : (cmfTimer_reg == 32'h0);
            framing_next[0] = (afTimer_reg == 32'h0);
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            framing_reg <= RXFL_RESET_VAL;
        end else begin
            framing_reg <= (framing_reg & ~(wr1c(RXFL_FRAMING_OFF) ? regWrData : 8'h00))
                         | framing_next;
        end
    end

    // Interrupt request from latched flags
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            alarmIrq <= 1'b0;
        end else begin
            alarmIrq <= (|alarm_reg)
                      || (isE1 && |framing_reg[3:0]);
        end
    end

    // Test pattern tap
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tapBitValid <= 1'b0;
            tapBit <= 1'b0;
        end else begin
            if (tapCtrl_reg[RXFL_TAP_SRC_BIT]) begin
                tapBitValid <= tapCtrl_reg[RXFL_TAP_EN_BIT] && txBitValid &&
                               !tapSupp_reg[channelBitIndex];
                tapBit <= txBit;
            end else begin
                tapBitValid <= tapCtrl_reg[RXFL_TAP_EN_BIT] && framerBitValid &&
                               (frameInfo.framingBitSlot ?
                                (!isE1 && tapCtrl_reg[RXFL_TAP_UNFR_BIT])
                                : !tapSupp_reg[channelBitIndex]);
                tapBit <= framerBit;
            end
        end
    end

    // HDLC tap: in Sa mode index 0..4 maps Sa4..Sa8 onto mask bits 4..0
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hdlcTapValid <= 1'b0;
            hdlcTapBit <= 1'b0;
        end else begin
            hdlcTapValid <= hdlcBitValid &&
                (mode_reg[RXFL_MODE_SA_BIT] && hdlcSaSlot
                    ? (hdlcBitIndex > 3'h4 ? 1'b0 : !hdlcSupp_reg[3'h4 - hdlcBitIndex])
                    : !hdlcSupp_reg[hdlcBitIndex]);
            hdlcTapBit <= hdlcBit;
        end
    end
endmodule : rxfl_latch_bank
`default_nettype wire

// ==== tb/rxfl_latch_bank_monitor.sv ====
// Checker for the receive latch bank port behaviour
`timescale 1ns/10ps
`default_nettype none
module rxfl_latch_bank_monitor
    import rxfl_pkg::*;
#(
    parameter int CMF_CYCLES = RXFL_CMF_CYCLES,
    parameter int AF_CYCLES = RXFL_AF_CYCLES
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    input wire logic [7:0] regRdData,
    input wire logic lineBitValid,
    input wire logic lineBit,
    input wire logic remoteAlarmCondition,
    input wire logic frameLossCondition,
    input wire logic framerBitValid,
    input wire logic txBitValid,
    input wire logic hdlcBitValid,
    input wire logic tapBitValid,
    input wire logic hdlcTapValid,
    input wire logic alarmIrq,
    input wire rxfl_cond_t alarmConditions
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    logic [7:0] zeroRun;
    // Saturates so a long zero run keeps the condition asserted
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            zeroRun <= 8'h00;
        end else if (lineBitValid) begin
            zeroRun <= lineBit ? 8'h00 : (zeroRun == RXFL_LOS_ZEROS) ? zeroRun : zeroRun + 8'h01;
        end
    end
    tap_readback_a: assert property (regWrStb && regAddr == RXFL_TAP_SUPP_OFF ##1
        regRdStb && regAddr == RXFL_TAP_SUPP_OFF |=> regRdData == $past(regWrData, 2))
        else $error("tap mask readback differs");
    hdlc_readback_a: assert property (regWrStb && regAddr == RXFL_HDLC_SUPP_OFF ##1
        regRdStb && regAddr == RXFL_HDLC_SUPP_OFF |=> regRdData == $past(regWrData, 2))
        else $error("hdlc mask readback differs");
    tap_cause_a: assert property (tapBitValid |-> $past(framerBitValid || txBitValid))
        else $error("tap bit without source bit");
    hdlc_cause_a: assert property (hdlcTapValid |-> $past(hdlcBitValid))
        else $error("hdlc tap bit without source bit");
    lof_irq_a: assert property ($rose(frameLossCondition) |-> ##[1:3] alarmIrq)
        else $error("frame loss rise raised no request");
    lof_clear_irq_a: assert property ($fell(frameLossCondition) |-> ##[1:3] alarmIrq)
        else $error("frame loss fall raised no request");
    rai_irq_a: assert property ($rose(remoteAlarmCondition) |-> ##[1:3] alarmIrq)
        else $error("remote alarm rise raised no request");
    lof_cond_a: assert property ($rose(frameLossCondition) |=> alarmConditions.frameLoss)
        else $error("frame loss condition not shown");
    los_detect_a: assert property (zeroRun == RXFL_LOS_ZEROS |->
        ##[0:3] alarmConditions.signalLoss)
        else $error("signal loss missing after zero run");
    cover property (tapBitValid && txBitValid);
    cover property (alarmConditions.signalLoss);
    cover property (alarmConditions.allOnesAlarm);
endmodule : rxfl_latch_bank_monitor
bind rxfl_latch_bank rxfl_latch_bank_monitor
    #(.CMF_CYCLES(CMF_CYCLES), .AF_CYCLES(AF_CYCLES)) mon (
    .mclk(mclk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .lineBitValid(lineBitValid), .lineBit(lineBit), .remoteAlarmCondition(remoteAlarmCondition),
    .frameLossCondition(frameLossCondition), .framerBitValid(framerBitValid),
    .txBitValid(txBitValid), .hdlcBitValid(hdlcBitValid), .tapBitValid(tapBitValid),
    .hdlcTapValid(hdlcTapValid), .alarmIrq(alarmIrq), .alarmConditions(alarmConditions)
);
`default_nettype wire

// ==== tb/rxfl_line_model.sv ====
// Far-end line transmitter model: sends runs of bits to the receiver
`timescale 1ns/10ps
`default_nettype none
module rxfl_line_model (
    input wire logic mclk,
    output logic lineBitValid,
    output logic lineBit
);
    initial begin
        lineBitValid = 1'b0;
        lineBit = 1'b1;
    end
    // Idle line shows the inverse so a stale value never passes for data
    task automatic send(input int n, input logic val);
        for (int i = 0; i < n; i++) begin
            lineBitValid <= 1'b1;
            lineBit <= val;
            @(posedge mclk);
        end
        lineBitValid <= 1'b0;
        lineBit <= ~val;
        #1;
    endtask : send
endmodule : rxfl_line_model
`default_nettype wire

// ==== tb/tb.sv ====
// Testbench for the receive latch bank
`timescale 1ns/10ps
`default_nettype none
module tb;
    import rxfl_pkg::*;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWrStb = 1'b0;
    logic regRdStb = 1'b0;
    logic remoteAlarmCondition = 1'b0;
    logic frameLossCondition = 1'b0;
    rxfl_frame_t frameInfo = '0;
    rxfl_frame_t ef;
    logic framerBitValid = 1'b0;
    logic txBitValid = 1'b0;
    logic [2:0] channelBitIndex = 3'h0;
    logic hdlcBitValid = 1'b0;
    logic [2:0] hdlcBitIndex = 3'h0;
    logic hdlcSaSlot = 1'b0;
    logic [7:0] regRdData;
    logic lineBitValid, lineBit, tapBitValid, tapBit, hdlcTapValid, hdlcTapBit, alarmIrq;
    rxfl_cond_t alarmConditions;
    logic [7:0] regs [4] = '{RXFL_TAP_SUPP_OFF, RXFL_HDLC_SUPP_OFF, RXFL_ALARM_OFF, 8'h91};
    int num_errors = 0;
    int check_count = 0;
    always #2.5 mclk = ~mclk;
    // Short timer periods keep the periodic events inside a brief run
    rxfl_latch_bank #(.CMF_CYCLES(40), .AF_CYCLES(10)) dut (
        .mclk(mclk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
        .lineBitValid(lineBitValid), .lineBit(lineBit),
        .remoteAlarmCondition(remoteAlarmCondition), .frameLossCondition(frameLossCondition),
        .frameInfo(frameInfo), .framerBitValid(framerBitValid), .framerBit(1'b1),
        .txBitValid(txBitValid), .txBit(1'b0), .channelBitIndex(channelBitIndex),
        .hdlcBitValid(hdlcBitValid), .hdlcBit(1'b1), .hdlcBitIndex(hdlcBitIndex),
        .hdlcSaSlot(hdlcSaSlot), .tapBitValid(tapBitValid), .tapBit(tapBit),
        .hdlcTapValid(hdlcTapValid), .hdlcTapBit(hdlcTapBit), .alarmIrq(alarmIrq),
        .alarmConditions(alarmConditions)
    );
    rxfl_line_model line (.mclk(mclk), .lineBitValid(lineBitValid), .lineBit(lineBit));
    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regWrStb <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge mclk);
        regWrStb <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what,
                      input logic [7:0] m = 8'hFF);
        regRdStb <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRdStb <= 1'b0;
        #1 chk(regRdData & m, exp, what);
    endtask : rd
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : idle
    // Framer bit is always 1 and transmit bit 0, so the source shows in the tap bit
    task automatic tap(input logic [2:0] idx, input logic slot,
                       input logic expV, input logic expB);
        framerBitValid <= 1'b1;
        txBitValid <= 1'b1;
        channelBitIndex <= idx;
        frameInfo.framingBitSlot <= slot;
        @(posedge mclk);
        framerBitValid <= 1'b0;
        txBitValid <= 1'b0;
        frameInfo.framingBitSlot <= 1'b0;
        #1 chk({6'h00, tapBitValid, tapBit & expV}, {6'h00, expV, expB & expV}, "tap");
    endtask : tap
    task automatic hd(input logic [2:0] idx, input logic sa, input logic expV);
        hdlcBitValid <= 1'b1;
        hdlcBitIndex <= idx;
        hdlcSaSlot <= sa;
        @(posedge mclk);
        hdlcBitValid <= 1'b0;
        hdlcSaSlot <= 1'b0;
        #1 chk({6'h00, hdlcTapValid, hdlcTapBit & expV}, {6'h00, expV, expV}, "hdlc tap");
    endtask : hd
    task automatic ev(input int n);
        repeat (n) begin
            frameInfo <= ef;
            @(posedge mclk);
            frameInfo <= '0;
            #1;
        end
    endtask : ev
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        complete_run();
    end
    initial begin
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        idle(1);
        foreach (regs[i]) begin
            rd(regs[i], 8'h00, "reset value");
        end
        wr(RXFL_TAP_SUPP_OFF, 8'hA5);
        rd(RXFL_TAP_SUPP_OFF, 8'hA5, "tap mask");
        wr(RXFL_HDLC_SUPP_OFF, 8'h5A);
        rd(RXFL_HDLC_SUPP_OFF, 8'h5A, "hdlc mask");
        rd(8'h55, 8'h00, "unmapped");
        wr(RXFL_TAP_SUPP_OFF, 8'h80);
        wr(RXFL_TAP_CTRL_OFF, 8'h01);
        tap(3'h7, 1'b0, 1'b0, 1'b0);
        tap(3'h0, 1'b0, 1'b1, 1'b1);
        tap(3'h0, 1'b1, 1'b0, 1'b0);
        wr(RXFL_TAP_CTRL_OFF, 8'h03);
        tap(3'h0, 1'b1, 1'b1, 1'b1);
        wr(RXFL_TAP_CTRL_OFF, 8'h05);
        tap(3'h0, 1'b0, 1'b1, 1'b0);
        wr(RXFL_TAP_CTRL_OFF, 8'h04);
        tap(3'h0, 1'b0, 1'b0, 1'b0);
        wr(RXFL_TAP_SUPP_OFF, 8'h01);
        wr(RXFL_TAP_CTRL_OFF, 8'h01);
        tap(3'h0, 1'b0, 1'b0, 1'b0);
        tap(3'h7, 1'b0, 1'b1, 1'b1);
        wr(RXFL_HDLC_SUPP_OFF, 8'h10);
        hd(3'h4, 1'b0, 1'b0);
        hd(3'h0, 1'b0, 1'b1);
        wr(RXFL_MODE_OFF, 8'h05);
        hd(3'h0, 1'b1, 1'b0);
        hd(3'h4, 1'b1, 1'b1);
        wr(RXFL_MODE_OFF, 8'h00);
        wr(8'h91, 8'hFF);
        frameLossCondition <= 1'b1;
        idle(4);
        rd(RXFL_ALARM_OFF, 8'h01, "alarm flags");
        chk({7'h00, alarmIrq}, 8'h01, "irq");
        line.send(192, 1'b1);
        line.send(191, 1'b0);
        idle(3);
        rd(RXFL_ALARM_OFF, 8'h45, "alarm flags");
        line.send(1, 1'b0);
        idle(3);
        rd(RXFL_ALARM_OFF, 8'h47, "alarm flags");
        rd(8'h91, 8'h18, "zero runs");
        wr(RXFL_ALARM_OFF, 8'hFF);
        rd(RXFL_ALARM_OFF, 8'h00, "alarm clear");
        idle(3);
        chk({7'h00, alarmIrq}, 8'h00, "irq");
        frameLossCondition <= 1'b0;
        remoteAlarmCondition <= 1'b1;
        idle(4);
        rd(RXFL_ALARM_OFF, 8'h18, "alarm flags");
        remoteAlarmCondition <= 1'b0;
        idle(4);
        rd(RXFL_ALARM_OFF, 8'h98, "alarm flags");
        wr(RXFL_ALARM_OFF, 8'hFF);
        wr(8'h91, 8'hFF);
        ef = '0;
        ef.b8zsCodeword = 1'b1;
        ev(1);
        rd(8'h91, 8'h02, "codeword");
        ef = '0;
        ef.framingBitSlot = 1'b1;
        ef.framingBitError = 1'b1;
        ev(1);
        rd(8'h91, 8'h03, "framing error");
        ev(1);
        rd(8'h91, 8'h07, "severe framing");
        ef = '0;
        ef.resyncDone = 1'b1;
        ef.alignChanged = 1'b1;
        ev(1);
        rd(8'h91, 8'h27, "alignment change");
        wr(RXFL_MODE_OFF, 8'h01);
        wr(8'h91, 8'hFF);
        ef = '0;
        ef.fasWordDone = 1'b1;
        ef.fasWordError = 1'b1;
        ev(2);
        rd(8'h91, 8'h00, "frame resync", 8'hFC);
        ev(1);
        rd(8'h91, 8'h10, "frame resync", 8'hFC);
        ef = '0;
        ef.mfWordDone = 1'b1;
        ef.mfWordError = 1'b1;
        ev(1);
        rd(8'h91, 8'h10, "mf resync", 8'hFC);
        ev(1);
        rd(8'h91, 8'h30, "mf resync", 8'hFC);
        ef = '0;
        ef.crcWordDone = 1'b1;
        ef.crcWordError = 1'b1;
        ev(914);
        rd(8'h91, 8'h00, "crc resync", 8'h40);
        ev(1);
        rd(8'h91, 8'h40, "crc resync", 8'h40);
        ef = '0;
        ef.ts16Valid = 1'b1;
        ef.ts16Byte = 8'hFF;
        ev(15);
        rd(8'h91, 8'h00, "ts16", 8'h0C);
        // Sixteenth all-ones frame also closes a multiframe without any zeros
        ef.mfBoundary = 1'b1;
        ev(1);
        ef.mfBoundary = 1'b0;
        ef.ts16Byte = 8'h00;
        ev(15);
        rd(8'h91, 8'h08, "ts16", 8'h0C);
        ef.mfBoundary = 1'b1;
        ev(1);
        rd(8'h91, 8'h0C, "ts16", 8'h0C);
        idle(45);
        rd(8'h91, 8'h03, "periodic", 8'h03);
        chk({7'h00, alarmIrq}, 8'h01, "irq");
        complete_run();
    end
endmodule : tb
`default_nettype wire
